// File: wake_regs.svh
`ifndef WAKE_REGS_SVH
`define WAKE_REGS_SVH

// Register byte addresses on the control bus.
`define DET_CTRL_OFFSET 8'h00
`define STATUS_OFFSET 8'h04
`define WAKE_EN_OFFSET 8'h08
`define ADDR_WORD_MASK 8'hFC

// Field positions of the detector control register.
`define THRESH_MSB 2
`define THRESH_LSB 0
`define DET_ON_BIT 4
`define LOW_FLAG_BIT 5

// Field positions of the status register.
`define ST_PDF_BIT 0
`define ST_TO_BIT 1
`define ST_LSR_BIT 2
`define ST_SLEEP_BIT 3

// Reset values.
`define DET_CTRL_RESET 8'h00
`define WAKE_EN_RESET 8'h00

// Bus responses.
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// Sizes.
`define PORT_W 8
`define IRQ_NUM 4
`define DLY_CNT_W 8

// Timing: the interrupt raise delay in ns and its cycle count at 8 ns per clock.
`define CLK_PERIOD_NS 8
`define IRQ_RAISE_DELAY_NS 1000
`define IRQ_RAISE_DELAY_CYC ((`IRQ_RAISE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: wake_pkg.sv
package wake_pkg;

    // Power state of the core as seen by the wake-up logic.
    typedef enum logic {
        RUN_MODE,
        HALTED
    } power_state_t;

    // Cause of the last wake-up.
    typedef enum logic [2:0] {
        CAUSE_NONE,
        CAUSE_EXT_RESET,
        CAUSE_WDT,
        CAUSE_PORT,
        CAUSE_IRQ
    } wake_cause_t;

endpackage : wake_pkg

// File: low_sense_if.sv
`timescale 1ns/1ps

// Carries the synchronised low-supply level to the delay timer and its set pulse back.
interface low_sense_if;
    logic low_level;
    logic irq_set;
    modport ctrl (output low_level, input irq_set);
    modport timer (input low_level, output irq_set);
endinterface : low_sense_if

// File: sync2.sv
`timescale 1ns/1ps

module sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic aclk, // System clock.
    input wire logic aresetn, // Synchronous reset, active low.
    input wire logic [WIDTH-1:0] d, // Asynchronous inputs.
    output logic [WIDTH-1:0] q // Synchronised outputs.
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] q_next;

    // The first stage feeds only the second stage.
    always_comb begin
        meta_next = d;
        q_next = meta_reg;
    end

    // Both stages clear to zero under reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= meta_next;
            q <= q_next;
        end
    end

endmodule : sync2

// File: irq_delay.sv
`timescale 1ns/1ps
`include "wake_regs.svh"

module irq_delay (
    input wire logic aclk, // System clock.
    input wire logic aresetn, // Synchronous reset, active low.
    low_sense_if.timer lsi // Low level in, set pulse out.
);

    localparam logic [`DLY_CNT_W-1:0] DELAY = `DLY_CNT_W'(`IRQ_RAISE_DELAY_CYC);

    logic [`DLY_CNT_W-1:0] cnt_reg;
    logic [`DLY_CNT_W-1:0] cnt_next;
    logic set_reg;
    logic set_next;
    logic [`DLY_CNT_W-1:0] run_reg;

    assign lsi.irq_set = set_reg;

    // Count the cycles the low level has held; a drop restarts the wait so every rise is timed.
    always_comb begin
        cnt_next = cnt_reg;
        set_next = 1'b0;
        if (!lsi.low_level) begin
            cnt_next = '0;
        end else begin
            if (cnt_reg != DELAY) begin
                cnt_next = cnt_reg + 1'b1;
            end
            set_next = (cnt_reg == DELAY - 1'b1);
        end
    end

    // Registers of the delay timer.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= '0;
            set_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            set_reg <= set_next;
        end
    end

    // Helper that counts consecutive low cycles, saturating.
    always_ff @(posedge aclk) begin
        if (!aresetn || !lsi.low_level) begin
            run_reg <= '0;
        end else if (run_reg != {`DLY_CNT_W{1'b1}}) begin
            run_reg <= run_reg + 1'b1;
        end
    end

    // The set pulse appears exactly after the full delay of held low level.
    a_raise_after_delay: assert property (@(posedge aclk) disable iff (!aresetn)
        lsi.irq_set |-> run_reg == DELAY)
        else $error("Low-supply request raised before the delay elapsed.");

    // A rise of the level held for the full delay produces a pulse of one cycle only.
    a_single_set_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
        lsi.irq_set |=> !lsi.irq_set)
        else $error("Low-supply set pulse longer than one cycle.");

    c_delay_done: cover property (@(posedge aclk) disable iff (!aresetn) lsi.irq_set);

endmodule : irq_delay

// File: sleep_wake_ctrl.sv
`timescale 1ns/1ps
`include "wake_regs.svh"

// Contract
// - In sleep, wake on external reset, port fall, interrupt or watchdog overflow.
// - Wake by external reset issues a full system reset.
// - Watchdog wake sets timeout flag, resets only PC and SP.
// - Power-down flag clears at power-up and watchdog clear, sets on halt.
// - Each port pin has a wake enable; enabled falling edge resumes after halt.
// - Disabled interrupt or full stack: resume after halt, request stays pending.
// - Enabled interrupt with stack room: normal interrupt response at once.
// - A request flag already high at sleep entry cannot wake.
// - Threshold field bits 2..0 selects one of eight detection voltages.
// - Read-only bit 5 shows one while supply is below threshold.
// - Bit 4 switches the detector on or off.
// - Bits 7, 6 and 3 of detector control read zero.
// - Low-supply request raised only after a fixed delay following flag rise.
// - Enabled detector runs in sleep; low supply sets request and wakes.
// - The low flag may toggle near threshold; each transition is handled.
// - Interrupt service leaves the low-supply request set until software clears it.
// - Any request flag rising wakes, whether enabled or not; the code wakes only on flags that were low at sleep entry.
module sleep_wake_ctrl (
    input wire logic aclk, // System clock, 125 MHz.
    input wire logic aresetn, // Power-up reset, synchronous, active low.
    input wire logic [7:0] awaddr, // Write address.
    input wire logic awvalid, // Write address valid.
    output logic awready, // Write address ready.
    input wire logic [31:0] wdata, // Write data.
    input wire logic [3:0] wstrb, // Write byte strobes.
    input wire logic wvalid, // Write data valid.
    output logic wready, // Write data ready.
    output logic [1:0] bresp, // Write response.
    output logic bvalid, // Write response valid.
    input wire logic bready, // Write response ready.
    input wire logic [7:0] araddr, // Read address.
    input wire logic arvalid, // Read address valid.
    output logic arready, // Read address ready.
    output logic [31:0] rdata, // Read data.
    output logic [1:0] rresp, // Read response.
    output logic rvalid, // Read data valid.
    input wire logic rready, // Read data ready.
    input wire logic ext_reset_n, // External reset pin, active low.
    input wire logic [`PORT_W-1:0] port_pins, // First-port pins.
    input wire logic comparator_low, // Analog comparator, high when supply is low.
    input wire logic halt_exec, // Halt instruction executes, pulse.
    input wire logic wdt_clear, // Watchdog clear instruction executes, pulse.
    input wire logic wdt_overflow, // Watchdog overflow, pulse.
    input wire logic [`IRQ_NUM-1:0] irq_flags, // Other interrupt request flags.
    input wire logic [`IRQ_NUM:0] irq_enable, // Full enable path per flag, top is low supply.
    input wire logic stack_full, // Stack has no free level.
    output logic core_clock_run, // System clock enable, low in sleep.
    output logic full_reset_req, // Full system reset, pulse.
    output logic wdt_reset_req, // Reset of PC and SP only, pulse.
    output logic resume_after_halt, // Continue after halt, pulse.
    output logic irq_take, // Start interrupt response, pulse.
    output wake_pkg::wake_cause_t wake_cause, // Cause of last wake-up.
    output logic detector_power, // Detector circuit on.
    output logic [2:0] threshold_select, // Selected detection voltage.
    output logic low_supply_flag, // Supply below threshold.
    output logic low_supply_irq_request // Low-supply request flag.
);

    low_sense_if lsi ();

    logic [`PORT_W+1:0] pins_sync;
    logic ext_now;
    logic [`PORT_W-1:0] port_now;
    logic ext_prev_reg;
    logic [`PORT_W-1:0] port_prev_reg;
    logic ext_fall;
    logic [`PORT_W-1:0] port_fall;
    logic [`IRQ_NUM:0] all_flags;
    logic [`IRQ_NUM:0] flags_prev_reg;
    logic [`IRQ_NUM:0] armed_reg;
    logic [`IRQ_NUM:0] armed_next;
    logic [`IRQ_NUM:0] irq_rise;
    wake_pkg::power_state_t state_reg;
    wake_pkg::power_state_t state_next;
    wake_pkg::wake_cause_t cause_next;
    logic full_next;
    logic wdtr_next;
    logic resume_next;
    logic take_next;
    logic pdf_reg;
    logic pdf_next;
    logic to_reg;
    logic to_next;
    logic [2:0] thresh_reg;
    logic [2:0] thresh_next;
    logic det_on_reg;
    logic det_on_next;
    logic low_flag_reg;
    logic low_flag_next;
    logic lsr_reg;
    logic lsr_next;
    logic [`PORT_W-1:0] wake_en_reg;
    logic [`PORT_W-1:0] wake_en_next;
    logic [7:0] aw_addr_reg;
    logic [7:0] aw_addr_next;
    logic aw_hold_reg;
    logic aw_hold_next;
    logic [7:0] w_data_reg;
    logic [7:0] w_data_next;
    logic w_lane_reg;
    logic w_lane_next;
    logic w_hold_reg;
    logic w_hold_next;
    logic bvalid_next;
    logic [1:0] bresp_next;
    logic rvalid_next;
    logic [31:0] rdata_next;
    logic [1:0] rresp_next;
    logic do_write;
    logic wr_ctrl;
    logic wr_status;
    logic wr_wake;
    logic rd_ctrl_reg;
    logic rd_ctrl_next;
    logic [7:0] ar_word;

    // Pins and the comparator enter through two flip-flops.
    sync2 #(.WIDTH(`PORT_W + 2)) u_pin_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d({comparator_low, ext_reset_n, port_pins}),
        .q(pins_sync)
    );

    irq_delay u_irq_delay (
        .aclk(aclk),
        .aresetn(aresetn),
        .lsi(lsi)
    );

    // Edge detection on the synchronised pins; previous values reset low so no false edge.
    assign ext_now = pins_sync[`PORT_W];
    assign port_now = pins_sync[`PORT_W-1:0];
    assign ext_fall = ext_prev_reg & ~ext_now;
    assign port_fall = port_prev_reg & ~port_now & wake_en_reg;
    assign all_flags = {lsr_reg, irq_flags};
    assign irq_rise = all_flags & ~flags_prev_reg & armed_reg;
    assign lsi.low_level = low_flag_reg;

    // Bus handshake outputs.
    assign awready = !aw_hold_reg && !bvalid;
    assign wready = !w_hold_reg && !bvalid;
    assign arready = !rvalid;
    assign do_write = aw_hold_reg && w_hold_reg && !bvalid && w_lane_reg;
    assign wr_ctrl = do_write && aw_addr_reg == `DET_CTRL_OFFSET;
    assign wr_status = do_write && aw_addr_reg == `STATUS_OFFSET;
    assign wr_wake = do_write && aw_addr_reg == `WAKE_EN_OFFSET;
    assign ar_word = araddr & `ADDR_WORD_MASK;

    // Block outputs from their registers.
    assign core_clock_run = (state_reg == wake_pkg::RUN_MODE);
    assign detector_power = det_on_reg;
    assign threshold_select = thresh_reg;
    assign low_supply_flag = low_flag_reg;
    assign low_supply_irq_request = lsr_reg;

    // Sleep state machine, wake-up priority and status flags.
    always_comb begin
        state_next = state_reg;
        cause_next = wake_cause;
        armed_next = armed_reg;
        full_next = 1'b0;
        wdtr_next = 1'b0;
        resume_next = 1'b0;
        take_next = 1'b0;
        pdf_next = pdf_reg;
        to_next = to_reg;
        if (wdt_clear) begin
            pdf_next = 1'b0;
        end
        if (ext_fall) begin
            full_next = 1'b1;
        end
        case (state_reg)
            wake_pkg::RUN_MODE: begin
                if (halt_exec) begin
                    state_next = wake_pkg::HALTED;
                    armed_next = ~all_flags;
                    pdf_next = 1'b1;
                    to_next = 1'b0;
                end
            end
            wake_pkg::HALTED: begin
                if (ext_fall) begin
                    state_next = wake_pkg::RUN_MODE;
                    cause_next = wake_pkg::CAUSE_EXT_RESET;
                end else if (wdt_overflow) begin
                    state_next = wake_pkg::RUN_MODE;
                    cause_next = wake_pkg::CAUSE_WDT;
                    wdtr_next = 1'b1;
                end else if (port_fall != '0) begin
                    state_next = wake_pkg::RUN_MODE;
                    cause_next = wake_pkg::CAUSE_PORT;
                    resume_next = 1'b1;
                end else if (irq_rise != '0) begin
                    state_next = wake_pkg::RUN_MODE;
                    cause_next = wake_pkg::CAUSE_IRQ;
                    if ((irq_rise & irq_enable) != '0 && !stack_full) begin
                        take_next = 1'b1;
                    end else begin
                        resume_next = 1'b1;
                    end
                end
            end
            default: begin
                state_next = wake_pkg::RUN_MODE;
            end
        endcase
        if (wdt_overflow) begin
            to_next = 1'b1;
        end
    end

    // Detector control, request flag and wake enables; hardware set wins over a software clear.
    always_comb begin
        thresh_next = thresh_reg;
        det_on_next = det_on_reg;
        wake_en_next = wake_en_reg;
        lsr_next = lsr_reg;
        low_flag_next = det_on_reg & pins_sync[`PORT_W+1];
        if (wr_ctrl) begin
            thresh_next = w_data_reg[`THRESH_MSB:`THRESH_LSB];
            det_on_next = w_data_reg[`DET_ON_BIT];
        end
        if (wr_wake) begin
            wake_en_next = w_data_reg;
        end
        if (wr_status) begin
            lsr_next = w_data_reg[`ST_LSR_BIT];
        end
        if (lsi.irq_set) begin
            lsr_next = 1'b1;
        end
    end

    // Bus slave: address and data are taken in either order, the write lands once both are held and byte strobe 0 was set.
    always_comb begin
        aw_addr_next = aw_addr_reg;
        aw_hold_next = aw_hold_reg;
        w_data_next = w_data_reg;
        w_lane_next = w_lane_reg;
        w_hold_next = w_hold_reg;
        bvalid_next = bvalid;
        bresp_next = bresp;
        rvalid_next = rvalid;
        rdata_next = rdata;
        rresp_next = rresp;
        rd_ctrl_next = rd_ctrl_reg;
        if (awvalid && awready) begin
            aw_addr_next = awaddr & `ADDR_WORD_MASK;
            aw_hold_next = 1'b1;
        end
        if (wvalid && wready) begin
            w_data_next = wdata[7:0];
            w_lane_next = wstrb[0];
            w_hold_next = 1'b1;
        end
        if (aw_hold_reg && w_hold_reg && !bvalid) begin
            aw_hold_next = 1'b0;
            w_hold_next = 1'b0;
            bvalid_next = 1'b1;
            if (aw_addr_reg == `DET_CTRL_OFFSET || aw_addr_reg == `STATUS_OFFSET ||
                aw_addr_reg == `WAKE_EN_OFFSET) begin
                bresp_next = `RESP_OKAY;
            end else begin
                bresp_next = `RESP_SLVERR;
            end
        end else if (bvalid && bready) begin
            bvalid_next = 1'b0;
        end
        if (arvalid && arready) begin
            rvalid_next = 1'b1;
            rresp_next = `RESP_OKAY;
            rdata_next = 32'h0000_0000;
            rd_ctrl_next = 1'b0;
            case (ar_word)
                `DET_CTRL_OFFSET: begin
                    rd_ctrl_next = 1'b1;
                    rdata_next[`THRESH_MSB:`THRESH_LSB] = thresh_reg;
                    rdata_next[`DET_ON_BIT] = det_on_reg;
                    rdata_next[`LOW_FLAG_BIT] = low_flag_reg;
                end
                `STATUS_OFFSET: begin
                    rdata_next[`ST_PDF_BIT] = pdf_reg;
                    rdata_next[`ST_TO_BIT] = to_reg;
                    rdata_next[`ST_LSR_BIT] = lsr_reg;
                    rdata_next[`ST_SLEEP_BIT] = (state_reg == wake_pkg::HALTED);
                end
                `WAKE_EN_OFFSET: begin
                    rdata_next[`PORT_W-1:0] = wake_en_reg;
                end
                default: begin
                    rresp_next = `RESP_SLVERR;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid_next = 1'b0;
        end
    end

    // Registers of all groups.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= wake_pkg::RUN_MODE;
            wake_cause <= wake_pkg::CAUSE_NONE;
            armed_reg <= '0;
            flags_prev_reg <= '0;
            ext_prev_reg <= 1'b0;
            port_prev_reg <= '0;
            full_reset_req <= 1'b0;
            wdt_reset_req <= 1'b0;
            resume_after_halt <= 1'b0;
            irq_take <= 1'b0;
            pdf_reg <= 1'b0;
            to_reg <= 1'b0;
            thresh_reg <= 3'(`DET_CTRL_RESET);
            det_on_reg <= 1'b0;
            low_flag_reg <= 1'b0;
            lsr_reg <= 1'b0;
            wake_en_reg <= `WAKE_EN_RESET;
            aw_addr_reg <= 8'h00;
            aw_hold_reg <= 1'b0;
            w_data_reg <= 8'h00;
            w_lane_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `RESP_OKAY;
            rd_ctrl_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            wake_cause <= cause_next;
            armed_reg <= armed_next;
            flags_prev_reg <= all_flags;
            ext_prev_reg <= ext_now;
            port_prev_reg <= port_now;
            full_reset_req <= full_next;
            wdt_reset_req <= wdtr_next;
            resume_after_halt <= resume_next;
            irq_take <= take_next;
            pdf_reg <= pdf_next;
            to_reg <= to_next;
            thresh_reg <= thresh_next;
            det_on_reg <= det_on_next;
            low_flag_reg <= low_flag_next;
            lsr_reg <= lsr_next;
            wake_en_reg <= wake_en_next;
            aw_addr_reg <= aw_addr_next;
            aw_hold_reg <= aw_hold_next;
            w_data_reg <= w_data_next;
            w_lane_reg <= w_lane_next;
            w_hold_reg <= w_hold_next;
            bvalid <= bvalid_next;
            bresp <= bresp_next;
            rvalid <= rvalid_next;
            rdata <= rdata_next;
            rresp <= rresp_next;
            rd_ctrl_reg <= rd_ctrl_next;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Checks on the wake-up sequence, flags and detector register.
    a_ext_full_reset: assert property (
        state_reg == wake_pkg::HALTED && ext_fall |=> full_reset_req && core_clock_run)
        else $error("External reset did not wake with a full reset.");
    a_wdt_wake_flags: assert property (
        state_reg == wake_pkg::HALTED && wdt_overflow && !ext_fall
        |=> wdt_reset_req && to_reg && pdf_reg == $past(pdf_reg) && !resume_after_halt)
        else $error("Watchdog wake did not set timeout or disturbed other flags.");
    a_halt_sets_pdf: assert property (
        state_reg == wake_pkg::RUN_MODE && halt_exec |=> pdf_reg && !core_clock_run)
        else $error("Halt did not set power-down flag and stop the clock.");
    a_clear_drops_pdf: assert property (
        wdt_clear && !(state_reg == wake_pkg::RUN_MODE && halt_exec) |=> !pdf_reg)
        else $error("Watchdog clear left power-down flag set.");
    a_port_wake_resume: assert property (
        state_reg == wake_pkg::HALTED && port_fall != '0 && !ext_fall && !wdt_overflow
        |=> resume_after_halt && wake_cause == wake_pkg::CAUSE_PORT)
        else $error("Enabled port fall did not resume after halt.");
    a_irq_wake_path: assert property (
        state_reg == wake_pkg::HALTED && irq_rise != '0 && !ext_fall && !wdt_overflow &&
        port_fall == '0 |=> irq_take == ($past(irq_rise & irq_enable) != '0 && !$past(stack_full))
        && resume_after_halt != irq_take)
        else $error("Interrupt wake took the wrong path.");
    a_stale_flag_sleeps: assert property (
        state_reg == wake_pkg::RUN_MODE && halt_exec && all_flags[`IRQ_NUM] ##1
        (all_flags[`IRQ_NUM] && irq_flags == '0 && !ext_fall && !wdt_overflow &&
        port_fall == '0) [*3] |-> state_reg == wake_pkg::HALTED)
        else $error("A flag high at sleep entry woke the core.");
    a_ctrl_unused_zero: assert property (
        rvalid && rd_ctrl_reg |-> rdata[7:6] == 2'b00 && !rdata[3] && rdata[31:8] == '0)
        else $error("Unused detector control bits read nonzero.");
    a_off_clears_flag: assert property (
        !det_on_reg ##1 !det_on_reg |-> !low_flag_reg)
        else $error("Low flag set while detector off.");
    a_set_reaches_request: assert property (
        lsi.irq_set |=> lsr_reg [*2])
        else $error("Low-supply set pulse was lost.");

    c_ext_wake: cover property (state_reg == wake_pkg::HALTED && ext_fall);
    c_wdt_wake: cover property (state_reg == wake_pkg::HALTED ##1 wdt_reset_req);
    c_port_wake: cover property (resume_after_halt && wake_cause == wake_pkg::CAUSE_PORT);
    c_irq_take: cover property (irq_take);

endmodule : sleep_wake_ctrl

// File: sleep_wake_ctrl_tb.sv
`timescale 1ns/1ps
module sleep_wake_ctrl_tb;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic bready = 1'b1, rready = 1'b1, ext_reset_n = 1'b1, comparator_low = 1'b0;
    logic halt_exec = 1'b0, wdt_clear = 1'b0, wdt_overflow = 1'b0, stack_full = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, port_pins = 8'hff;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'hf, irq_flags = 4'h0;
    logic [4:0] irq_enable = 5'h00;
    logic awready, wready, bvalid, arready, rvalid, core_clock_run, full_reset_req;
    logic wdt_reset_req, resume_after_halt, irq_take, detector_power, low_supply_flag;
    logic low_supply_irq_request;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, d;
    logic [2:0] threshold_select;
    wake_pkg::wake_cause_t wake_cause;
    logic [40:0] rd_q[$];
    logic [1:0] wr_q[$];
    logic [6:0] oe = 7'h40;
    logic [6:0] wk_q[$];
    int miscompares = 0;
    int checked = 0;

    // The block under test, joined to the bench signals of the same names.
    sleep_wake_ctrl sleep_wake_ctrl_i (.*);

    // Clock of 8 ns period.
    always #4 aclk = ~aclk;

    // Reports one miscompare with both values.
    task automatic miss(input logic [40:0] got, input logic [40:0] exp);
        miscompares++;
        $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    endtask : miss

    // Compares a read response with its note.
    task automatic chk_read(input logic [40:0] got, input logic [40:0] exp);
        checked++;
        if (got !== exp) miss(got, exp);
    endtask : chk_read

    // Compares the wake pulses and cause with their note.
    task automatic chk_wake(input logic [6:0] got, input logic [6:0] exp);
        checked++;
        if (got !== exp) miss({34'h0, got}, {34'h0, exp});
    endtask : chk_wake

    // Compares a write response with its note.
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        checked++;
        if (got !== exp) miss({39'h0, got}, {39'h0, exp});
    endtask : chk_resp

    // Checks each write response against the oldest note.
    always @(posedge aclk) begin
        if (bvalid && bready) begin
            chk_resp(bresp, wr_q.size() > 0 ? wr_q.pop_front() : 2'b11);
        end
    end

    // Checks each read response against the oldest note.
    always @(posedge aclk) begin
        if (rvalid && rready) begin
            chk_read({core_clock_run, low_supply_irq_request, detector_power, threshold_select,
                low_supply_flag, rresp, rdata}, rd_q.size() > 0 ? rd_q.pop_front() : '1);
        end
    end

    // Checks each wake pulse against the oldest note; an unnoted pulse fails.
    always @(posedge aclk) begin
        if (aresetn && (full_reset_req | wdt_reset_req | resume_after_halt | irq_take)) begin
            chk_wake({wake_cause, full_reset_req, wdt_reset_req, resume_after_halt, irq_take},
                wk_q.size() > 0 ? wk_q.pop_front() : 7'h7f);
        end
    end

    // Write with both channels offered together, each released when taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        wr_q.push_back(a inside {8'h00, 8'h04, 8'h08} ? 2'b00 : 2'b10);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        do @(posedge aclk); while (!bvalid);
    endtask : wr

    // Read that notes the expected response and data first.
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        rd_q.push_back({oe, e});
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
    endtask : rd

    // Notes the expected wake and executes a halt.
    task automatic halt_then(input logic [6:0] e);
        wk_q.push_back(e);
        halt_exec <= 1'b1;
        @(posedge aclk);
        halt_exec <= 1'b0;
        @(posedge aclk);
    endtask : halt_then

    // Waits, bounded, until the noted wake has shown.
    task automatic settle();
        for (int n = 0; n < 400 && wk_q.size() > 0; n++) @(posedge aclk);
        repeat (3) @(posedge aclk);
    endtask : settle

    // Prints the verdict; notes never matched count as miscompares.
    task automatic wrap_up();
        miscompares += rd_q.size() + wk_q.size() + wr_q.size();
        if (miscompares == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    // Main sequence of scenarios.
    initial begin
        void'($urandom(32'h3faa));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h00, 34'h0_0000_0000);
        d = $urandom;
        wr(8'h00, d);
        oe = {2'b10, d[4], d[2:0], 1'b0};
        rd(8'h00, {26'h000_0000, 1'b0, d[4], 1'b0, d[2:0]});
        rd(8'h0c, 34'h2_0000_0000);
        wr(8'h0c, 32'h0000_00ff);
        for (int i = 0; i < 3; i++) begin
            irq_enable <= {4'h0, i > 0};
            stack_full <= (i == 2);
            halt_then({3'(wake_pkg::CAUSE_IRQ), 2'b00, i != 1, i == 1});
            irq_flags <= 4'h1;
            settle();
            rd(8'h04, 34'h0_0000_0001);
            irq_flags <= 4'h0;
        end
        irq_flags <= 4'h2;
        wr(8'h08, 32'h0000_0001);
        halt_then({3'(wake_pkg::CAUSE_PORT), 4'b0010});
        repeat (20) @(posedge aclk);
        oe[6] = 1'b0;
        rd(8'h04, 34'h0_0000_0009);
        oe[6] = 1'b1;
        port_pins <= 8'hfe;
        settle();
        halt_then({3'(wake_pkg::CAUSE_WDT), 4'b0100});
        wdt_overflow <= 1'b1;
        @(posedge aclk);
        wdt_overflow <= 1'b0;
        settle();
        rd(8'h04, 34'h0_0000_0003);
        wdt_clear <= 1'b1;
        @(posedge aclk);
        wdt_clear <= 1'b0;
        rd(8'h04, 34'h0_0000_0002);
        wr(8'h04, 32'h0000_0000);
        wr(8'h00, 32'h0000_0015);
        halt_then({3'(wake_pkg::CAUSE_IRQ), 4'b0010});
        comparator_low <= 1'b1;
        settle();
        oe = 7'h7b;
        rd(8'h00, 34'h0_0000_0035);
        rd(8'h04, 34'h0_0000_0005);
        comparator_low <= 1'b0;
        repeat (5) @(posedge aclk);
        oe = 7'h7a;
        rd(8'h00, 34'h0_0000_0015);
        irq_flags <= 4'h0;
        halt_then({3'(wake_pkg::CAUSE_EXT_RESET), 4'b1000});
        ext_reset_n <= 1'b0;
        settle();
        wrap_up();
    end

    // Cuts a hang short.
    initial begin
        #100000;
        miscompares++;
        wrap_up();
    end
endmodule : sleep_wake_ctrl_tb
